// [src/acb_alu.sv]
// combinational byte and word arithmetic unit with status flag generation
`timescale 1ns/1ns
`default_nettype none
module acb_alu (
   acb_alu_if.alu bus
);
   logic [7:0] a8;
   logic [7:0] b8;
   logic [7:0] r8;
   logic [8:0] w9;
   logic [16:0] w17;
   logic [15:0] r16;
   logic [7:0] sr;
   logic cin;
   logic borrow_op;
   logic upd8;
   logic upd16;

   always_comb
   begin
      a8 = bus.opa[7:0];
      b8 = bus.opb[7:0];
      sr = bus.sreg_in;
      r8 = a8;
      r16 = bus.opa;
      w9 = 9'h000;
      w17 = 17'h00000;
      upd8 = 1'b0;
      upd16 = 1'b0;
      borrow_op = (bus.op == acb_pkg::OP_DIFFERENCE_WITH_BORROW) ||
                  (bus.op == acb_pkg::OP_CONSTANT_DIFFERENCE_WITH_BORROW);
      cin = bus.sreg_in[acb_pkg::FLAG_C] &
            (borrow_op || (bus.op == acb_pkg::OP_SUM_WITH_CARRY));
      unique case (bus.op)
         acb_pkg::OP_SUM, acb_pkg::OP_SUM_WITH_CARRY:
         begin
            w9 = {1'b0, a8} + {1'b0, b8} + {8'h00, cin};
            r8 = w9[7:0];
            upd8 = 1'b1;
            sr[acb_pkg::FLAG_C] = w9[8];
            sr[acb_pkg::FLAG_H] = (a8[3] & b8[3]) | (b8[3] & ~r8[3]) | (~r8[3] & a8[3]);
            sr[acb_pkg::FLAG_V] = (a8[7] & b8[7] & ~r8[7]) | (~a8[7] & ~b8[7] & r8[7]);
            sr[acb_pkg::FLAG_Z] = (r8 == 8'h00);
         end
         acb_pkg::OP_DIFFERENCE, acb_pkg::OP_CONSTANT_DIFFERENCE,
         acb_pkg::OP_DIFFERENCE_WITH_BORROW, acb_pkg::OP_CONSTANT_DIFFERENCE_WITH_BORROW:
         begin
            w9 = {1'b0, a8} - {1'b0, b8} - {8'h00, cin};
            r8 = w9[7:0];
            upd8 = 1'b1;
            sr[acb_pkg::FLAG_C] = w9[8];
            sr[acb_pkg::FLAG_H] = (~a8[3] & b8[3]) | (b8[3] & r8[3]) | (r8[3] & ~a8[3]);
            sr[acb_pkg::FLAG_V] = (a8[7] & ~b8[7] & ~r8[7]) | (~a8[7] & b8[7] & r8[7]);
            // borrow chains keep zero only if the lower byte was zero too
            sr[acb_pkg::FLAG_Z] = (r8 == 8'h00) &
                                  (~borrow_op | bus.sreg_in[acb_pkg::FLAG_Z]);
         end
         acb_pkg::OP_WORD_IMMEDIATE_SUM:
         begin
            w17 = {1'b0, bus.opa} + {1'b0, bus.opb};
            r16 = w17[15:0];
            upd16 = 1'b1;
            sr[acb_pkg::FLAG_V] = ~bus.opa[15] & r16[15];
            sr[acb_pkg::FLAG_C] = ~r16[15] & bus.opa[15];
         end
         acb_pkg::OP_WORD_IMMEDIATE_DIFF:
         begin
            w17 = {1'b0, bus.opa} - {1'b0, bus.opb};
            r16 = w17[15:0];
            upd16 = 1'b1;
            sr[acb_pkg::FLAG_V] = bus.opa[15] & ~r16[15];
            sr[acb_pkg::FLAG_C] = r16[15] & ~bus.opa[15];
         end
         acb_pkg::OP_CONJUNCTION, acb_pkg::OP_BITWISE_CONJUNCTION_CONSTANT,
         acb_pkg::OP_ZERO_SIGN_TEST:
         begin
            r8 = a8 & b8;
            upd8 = 1'b1;
         end
         acb_pkg::OP_DISJUNCTION, acb_pkg::OP_BITWISE_DISJUNCTION_CONSTANT,
         acb_pkg::OP_SET_BITS_MASK:
         begin
            r8 = a8 | b8;
            upd8 = 1'b1;
         end
         acb_pkg::OP_EXCLUSIVE_DISJUNCTION:
         begin
            r8 = a8 ^ b8;
            upd8 = 1'b1;
         end
         acb_pkg::OP_CLEAR_BITS_MASK:
         begin
            r8 = a8 & (acb_pkg::BYTE_ONES - b8);
            upd8 = 1'b1;
         end
         default:
         begin
            r8 = a8;
         end
      endcase
      if (upd8)
      begin
         r16 = {bus.opa[15:8], r8};
         sr[acb_pkg::FLAG_N] = r8[7];
         // logic codes sit above byte arithmetic; borrow-chained zero survives
         if (bus.op >= acb_pkg::OP_CONJUNCTION)
         begin
            sr[acb_pkg::FLAG_Z] = (r8 == 8'h00);
            sr[acb_pkg::FLAG_V] = 1'b0;
         end
      end
      if (upd16)
      begin
         sr[acb_pkg::FLAG_N] = r16[15];
         sr[acb_pkg::FLAG_Z] = (r16 == 16'h0000);
      end
      if (upd8 || upd16)
      begin
         sr[acb_pkg::FLAG_S] = sr[acb_pkg::FLAG_N] ^ sr[acb_pkg::FLAG_V];
      end
   end

   assign bus.res = r16;
   assign bus.sreg_out = sr;
endmodule : acb_alu
`default_nettype wire

// [src/acb_alu_if.sv]
// operand and result bundle between the core sequencer and its arithmetic unit
`timescale 1ns/1ns
`default_nettype none
interface acb_alu_if;
   acb_pkg::acb_op_t op;
   logic [15:0] opa;
   logic [15:0] opb;
   logic [7:0] sreg_in;
   logic [15:0] res;
   logic [7:0] sreg_out;

   modport core (output op, output opa, output opb, output sreg_in,
                 input res, input sreg_out);
   modport alu (input op, input opa, input opb, input sreg_in,
                output res, output sreg_out);
endinterface : acb_alu_if
`default_nettype wire

// [src/acb_core.sv]
// execution core: register file, sequencer, program counter and io bit access
`timescale 1ns/1ns
`default_nettype none
module acb_core (
   input wire logic mclk,
   input wire logic reset,
   input wire logic cmd_valid,
   input wire acb_pkg::acb_op_t cmd_op,
   input wire logic [4:0] cmd_rd,
   input wire logic [4:0] cmd_rr,
   input wire logic [7:0] cmd_k,
   input wire logic [11:0] cmd_offset,
   input wire logic cmd_next_two_words,
   output logic cmd_ready,
   output logic done,
   output logic [15:0] pc,
   output logic [7:0] sreg,
   output logic ret_push,
   output logic [15:0] ret_addr,
   output logic io_bit_we,
   output logic [4:0] io_addr,
   output logic [2:0] io_bit_sel,
   output logic io_bit_value,
   input wire logic [7:0] io_rd_data,
   input wire logic load_we,
   input wire logic [4:0] load_addr,
   input wire logic [7:0] load_data,
   input wire logic [4:0] peek_addr,
   output logic [7:0] peek_data
);
   // ----------------------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------------------
   logic [7:0] rf [0:31];
   acb_pkg::acb_core_st_t s_r;
   acb_pkg::acb_core_st_t s_nxt;

   acb_alu_if alu_bus ();

   acb_alu u_alu (
      .bus (alu_bus)
   );

   // ----------------------------------------------------------------------------
   // operand selection
   // ----------------------------------------------------------------------------
   logic [7:0] rd_val;
   logic [7:0] rr_val;
   logic [4:0] pair_lo;
   logic [4:0] pair_hi;
   logic [15:0] pointer;
   logic [15:0] pc_next;
   logic [15:0] pc_rel;
   logic accept;
   logic word_op;
   logic byte_op;
   logic io_hit;
   logic [1:0] cyc;
   logic wa_en;
   logic [4:0] wa_addr;
   logic [7:0] wa_data;
   logic wb_en;

   assign rd_val = rf[cmd_rd];
   assign rr_val = rf[cmd_rr];
   assign pair_lo = {cmd_rd[4:1], 1'b0};
   assign pair_hi = {cmd_rd[4:1], 1'b1};
   assign pointer = {rf[acb_pkg::POINTER_HI], rf[acb_pkg::POINTER_LO]};
   assign pc_next = s_r.pc + 16'h0001;
   assign pc_rel = s_r.pc + {{4{cmd_offset[11]}}, cmd_offset} + 16'h0001;
   assign accept = cmd_valid && s_r.ready && (s_r.state == acb_pkg::ST_IDLE);
   assign word_op = (cmd_op == acb_pkg::OP_WORD_IMMEDIATE_SUM) ||
                    (cmd_op == acb_pkg::OP_WORD_IMMEDIATE_DIFF);
   assign byte_op = (cmd_op <= acb_pkg::OP_ZERO_SIGN_TEST) && !word_op;
   assign io_hit = io_rd_data[s_r.io_bit] == s_r.skip_pol;

   always_comb
   begin
      alu_bus.op = cmd_op;
      alu_bus.sreg_in = s_r.sreg;
      alu_bus.opa = {8'h00, rd_val};
      alu_bus.opb = {8'h00, cmd_k};
      if (word_op)
      begin
         // word forms take a six bit constant on an even register pair
         alu_bus.opa = {rf[pair_hi], rf[pair_lo]};
         alu_bus.opb = {10'h000, cmd_k[5:0]};
      end
      else if (cmd_op == acb_pkg::OP_ZERO_SIGN_TEST)
      begin
         alu_bus.opb = {8'h00, rd_val};
      end
      else if (cmd_op inside {acb_pkg::OP_SUM, acb_pkg::OP_SUM_WITH_CARRY,
               acb_pkg::OP_DIFFERENCE,
               acb_pkg::OP_DIFFERENCE_WITH_BORROW,
               acb_pkg::OP_CONJUNCTION, acb_pkg::OP_DISJUNCTION,
               acb_pkg::OP_EXCLUSIVE_DISJUNCTION})
      begin
         alu_bus.opb = {8'h00, rr_val};
      end
   end

   // ----------------------------------------------------------------------------
   // register file write ports: a command result outranks the load port
   // ----------------------------------------------------------------------------
   always_comb
   begin
      wa_en = load_we;
      wa_addr = load_addr;
      wa_data = load_data;
      wb_en = 1'b0;
      if (accept && word_op)
      begin
         wa_en = 1'b1;
         wa_addr = pair_lo;
         wa_data = alu_bus.res[7:0];
         wb_en = 1'b1;
      end
      else if (accept && byte_op)
      begin
         wa_en = 1'b1;
         wa_addr = cmd_rd;
         wa_data = alu_bus.res[7:0];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (wa_en)
      begin
         rf[wa_addr] <= wa_data;
      end
      if (wb_en)
      begin
         rf[pair_hi] <= alu_bus.res[15:8];
      end
   end

   // ----------------------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      s_nxt.ret_push = 1'b0;
      s_nxt.io_we = 1'b0;
      s_nxt.peek = rf[peek_addr];
      cyc = acb_pkg::CYC_SINGLE;
      unique case (s_r.state)
         acb_pkg::ST_IDLE:
         begin
            if (accept)
            begin
               s_nxt.pc = pc_next;
               if (byte_op)
               begin
                  s_nxt.sreg = alu_bus.sreg_out;
               end
               unique case (cmd_op)
                  acb_pkg::OP_WORD_IMMEDIATE_SUM, acb_pkg::OP_WORD_IMMEDIATE_DIFF:
                  begin
                     s_nxt.sreg = alu_bus.sreg_out;
                     cyc = acb_pkg::CYC_WORD;
                  end
                  acb_pkg::OP_RELATIVE_SUBROUTINE_CALL:
                  begin
                     s_nxt.pc = pc_rel;
                     s_nxt.ret_push = 1'b1;
                     s_nxt.ret_addr = pc_next;
                     cyc = acb_pkg::CYC_CALL;
                  end
                  acb_pkg::OP_INDIRECT_JUMP_VIA_POINTER:
                  begin
                     s_nxt.pc = pointer;
                     cyc = acb_pkg::CYC_JUMP;
                  end
                  acb_pkg::OP_INDIRECT_SUBROUTINE_CALL:
                  begin
                     s_nxt.pc = pointer;
                     s_nxt.ret_push = 1'b1;
                     s_nxt.ret_addr = pc_next;
                     cyc = acb_pkg::CYC_CALL;
                  end
                  acb_pkg::OP_COMPARE_SKIP_EQUAL:
                  begin
                     if (rd_val == rr_val)
                     begin
                        // skipping a two-word instruction costs one more cycle
                        s_nxt.pc = cmd_next_two_words ? s_r.pc + 16'h0003
                                                      : s_r.pc + 16'h0002;
                        cyc = cmd_next_two_words ? 2'h3 : 2'h2;
                     end
                  end
                  acb_pkg::OP_IO_BIT_SET, acb_pkg::OP_IO_BIT_CLEAR:
                  begin
                     // a single-bit strobe, so write-one-to-clear flags in other
                     // bits of the same register are never hit by accident
                     s_nxt.io_we = 1'b1;
                     s_nxt.io_addr = cmd_rd;
                     s_nxt.io_bit = cmd_k[2:0];
                     s_nxt.io_value = (cmd_op == acb_pkg::OP_IO_BIT_SET);
                     cyc = acb_pkg::CYC_IO_BIT;
                  end
                  acb_pkg::OP_IO_BIT_SKIP_IF_ONE, acb_pkg::OP_IO_BIT_SKIP_IF_ZERO:
                  begin
                     s_nxt.pc = s_r.pc;
                     s_nxt.io_addr = cmd_rd;
                     s_nxt.io_bit = cmd_k[2:0];
                     s_nxt.skip_pol = (cmd_op == acb_pkg::OP_IO_BIT_SKIP_IF_ONE);
                     s_nxt.skip_two = cmd_next_two_words;
                     cyc = 2'h0;
                  end
                  default:
                  begin
                     cyc = acb_pkg::CYC_SINGLE;
                  end
               endcase
               if (cyc == 2'h0)
               begin
                  s_nxt.state = acb_pkg::ST_IO_READ;
                  s_nxt.ready = 1'b0;
               end
               else if (cyc == acb_pkg::CYC_SINGLE)
               begin
                  s_nxt.done = 1'b1;
               end
               else
               begin
                  s_nxt.state = acb_pkg::ST_WAIT;
                  s_nxt.cnt = cyc - 2'h1;
                  s_nxt.ready = 1'b0;
               end
            end
         end
         acb_pkg::ST_WAIT:
         begin
            if (s_r.cnt == 2'h1)
            begin
               s_nxt.state = acb_pkg::ST_IDLE;
               s_nxt.ready = 1'b1;
               s_nxt.done = 1'b1;
            end
            s_nxt.cnt = s_r.cnt - 2'h1;
         end
         acb_pkg::ST_IO_READ:
         begin
            // io data is valid a cycle after the address
            s_nxt.pc = pc_next;
            if (io_hit)
            begin
               s_nxt.pc = s_r.skip_two ? s_r.pc + 16'h0003 : s_r.pc + 16'h0002;
            end
            if (io_hit && s_r.skip_two)
            begin
               s_nxt.state = acb_pkg::ST_WAIT;
               s_nxt.cnt = 2'h1;
            end
            else
            begin
               s_nxt.state = acb_pkg::ST_IDLE;
               s_nxt.ready = 1'b1;
               s_nxt.done = 1'b1;
            end
         end
         default:
         begin
            s_nxt = acb_pkg::CORE_RESET;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         s_r <= acb_pkg::CORE_RESET;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------------
   assign cmd_ready = s_r.ready;
   assign done = s_r.done;
   assign pc = s_r.pc;
   assign sreg = s_r.sreg;
   assign ret_push = s_r.ret_push;
   assign ret_addr = s_r.ret_addr;
   assign io_bit_we = s_r.io_we;
   assign io_addr = s_r.io_addr;
   assign io_bit_sel = s_r.io_bit;
   assign io_bit_value = s_r.io_value;
   assign peek_data = s_r.peek;
endmodule : acb_core
`default_nettype wire

// [src/acb_pkg.sv]
// shared constants, types and the state record of the arithmetic, logic and branch core
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package acb_pkg;

   // ----------------------------------------------------------------------------
   // status register bit positions
   // ----------------------------------------------------------------------------
   localparam int unsigned FLAG_C = 0;
   localparam int unsigned FLAG_Z = 1;
   localparam int unsigned FLAG_N = 2;
   localparam int unsigned FLAG_V = 3;
   localparam int unsigned FLAG_S = 4;
   localparam int unsigned FLAG_H = 5;

   // ----------------------------------------------------------------------------
   // register file layout and reset values
   // ----------------------------------------------------------------------------
   localparam logic [4:0] POINTER_LO = 5'h1E;
   localparam logic [4:0] POINTER_HI = 5'h1F;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] SREG_RESET = 8'h00;
   localparam logic [7:0] BYTE_ONES = 8'hFF;

   // ----------------------------------------------------------------------------
   // cycle counts per instruction class
   // ----------------------------------------------------------------------------
   localparam logic [1:0] CYC_SINGLE = 2'h1;
   localparam logic [1:0] CYC_WORD = 2'h2;
   localparam logic [1:0] CYC_JUMP = 2'h2;
   localparam logic [1:0] CYC_CALL = 2'h3;
   localparam logic [1:0] CYC_IO_BIT = 2'h2;

   typedef enum logic [4:0] {
      OP_SUM                              = 5'h00,
      OP_SUM_WITH_CARRY                   = 5'h01,
      OP_WORD_IMMEDIATE_SUM               = 5'h02,
      OP_DIFFERENCE                       = 5'h03,
      OP_CONSTANT_DIFFERENCE              = 5'h04,
      OP_DIFFERENCE_WITH_BORROW           = 5'h05,
      OP_CONSTANT_DIFFERENCE_WITH_BORROW  = 5'h06,
      OP_WORD_IMMEDIATE_DIFF              = 5'h07,
      OP_CONJUNCTION                      = 5'h08,
      OP_BITWISE_CONJUNCTION_CONSTANT     = 5'h09,
      OP_DISJUNCTION                      = 5'h0A,
      OP_BITWISE_DISJUNCTION_CONSTANT     = 5'h0B,
      OP_EXCLUSIVE_DISJUNCTION            = 5'h0C,
      OP_SET_BITS_MASK                    = 5'h0D,
      OP_CLEAR_BITS_MASK                  = 5'h0E,
      OP_ZERO_SIGN_TEST                   = 5'h0F,
      OP_RELATIVE_SUBROUTINE_CALL         = 5'h10,
      OP_INDIRECT_JUMP_VIA_POINTER        = 5'h11,
      OP_INDIRECT_SUBROUTINE_CALL         = 5'h12,
      OP_COMPARE_SKIP_EQUAL               = 5'h13,
      OP_IO_BIT_SET                       = 5'h14,
      OP_IO_BIT_CLEAR                     = 5'h15,
      OP_IO_BIT_SKIP_IF_ONE               = 5'h16,
      OP_IO_BIT_SKIP_IF_ZERO              = 5'h17,
      OP_NONE                             = 5'h18
   } acb_op_t;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_WAIT    = 2'b01,
      ST_IO_READ = 2'b10
   } acb_state_t;

   typedef struct packed {
      acb_state_t state;
      logic [15:0] pc;
      logic [7:0] sreg;
      logic [1:0] cnt;
      logic ready;
      logic done;
      logic ret_push;
      logic [15:0] ret_addr;
      logic io_we;
      logic [4:0] io_addr;
      logic [2:0] io_bit;
      logic io_value;
      logic skip_pol;
      logic skip_two;
      logic [7:0] peek;
   } acb_core_st_t;

   localparam acb_core_st_t CORE_RESET = '{
      state: ST_IDLE, pc: PC_RESET, sreg: SREG_RESET, cnt: 2'h0, ready: 1'b1,
      done: 1'b0, ret_push: 1'b0, ret_addr: 16'h0000, io_we: 1'b0, io_addr: 5'h00,
      io_bit: 3'h0, io_value: 1'b0, skip_pol: 1'b0, skip_two: 1'b0, peek: 8'h00};

endpackage : acb_pkg

// [testbench/acb_core_assertions.sv]
// concurrent checks on the execution core ports
`timescale 1ns/1ns
`default_nettype none
module acb_core_assertions (
   input wire logic mclk,
   input wire logic reset,
   input wire logic cmd_valid,
   input wire acb_pkg::acb_op_t cmd_op,
   input wire logic [4:0] cmd_rd,
   input wire logic [7:0] cmd_k,
   input wire logic cmd_ready,
   input wire logic done,
   input wire logic [15:0] pc,
   input wire logic [7:0] sreg,
   input wire logic ret_push,
   input wire logic [15:0] ret_addr,
   input wire logic io_bit_we,
   input wire logic [4:0] io_addr,
   input wire logic [2:0] io_bit_sel,
   input wire logic io_bit_value
);
   logic acc;
   assign acc = cmd_valid & cmd_ready;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // ----------------------------------------------------------------------------
   // timing, flag effects and io bit access
   // ----------------------------------------------------------------------------
   property p_byte_one;
      acc && cmd_op inside {5'h00, 5'h01, [5'h03:5'h06], [5'h08:5'h0F]} |=> done && cmd_ready;
   endproperty
   a_byte_one: assert property (p_byte_one) else $error("byte op not done in one cycle");
   property p_word_two;
      acc && cmd_op inside {acb_pkg::OP_WORD_IMMEDIATE_SUM, acb_pkg::OP_WORD_IMMEDIATE_DIFF}
         |=> !cmd_ready && !done ##1 done && cmd_ready;
   endproperty
   a_word_two: assert property (p_word_two) else $error("word op not two cycles");
   property p_call_push;
      acc && cmd_op inside {acb_pkg::OP_RELATIVE_SUBROUTINE_CALL, acb_pkg::OP_INDIRECT_SUBROUTINE_CALL}
         |=> ret_push && ret_addr == $past(pc) + 16'h0001 ##1 !cmd_ready ##1 done && cmd_ready;
   endproperty
   a_call_push: assert property (p_call_push) else $error("call return point or timing wrong");
   property p_jump_two;
      acc && cmd_op == acb_pkg::OP_INDIRECT_JUMP_VIA_POINTER |=> !ret_push && !cmd_ready ##1 done;
   endproperty
   a_jump_two: assert property (p_jump_two) else $error("indirect jump timing wrong");
   property p_flow_flags;
      acc && cmd_op inside {[5'h10:5'h17]} |=> $stable(sreg);
   endproperty
   a_flow_flags: assert property (p_flow_flags) else $error("flow op altered flags");
   property p_logic_carry;
      acc && cmd_op inside {[5'h08:5'h0F]} |=> sreg[0] == $past(sreg[0]) && !sreg[3];
   endproperty
   a_logic_carry: assert property (p_logic_carry) else $error("logic op touched carry");
   property p_io_set;
      acc && cmd_op == acb_pkg::OP_IO_BIT_SET |=> io_bit_we && io_bit_value
         && io_addr == $past(cmd_rd) && {5'h00, io_bit_sel} == ($past(cmd_k) & 8'h07)
         ##1 !io_bit_we && done && cmd_ready;
   endproperty
   a_io_set: assert property (p_io_set) else $error("io bit set wrong");
   property p_io_clear;
      acc && cmd_op == acb_pkg::OP_IO_BIT_CLEAR |=> io_bit_we && !io_bit_value
         && io_addr == $past(cmd_rd) ##1 !io_bit_we && done;
   endproperty
   a_io_clear: assert property (p_io_clear) else $error("io bit clear wrong");
   property p_io_pulse;
      io_bit_we |=> !io_bit_we;
   endproperty
   a_io_pulse: assert property (p_io_pulse) else $error("io bit write not a pulse");
   c_word: cover property (acc && cmd_op == acb_pkg::OP_WORD_IMMEDIATE_SUM);
   c_call: cover property (ret_push);
   c_skip: cover property (acc && cmd_op == acb_pkg::OP_IO_BIT_SKIP_IF_ONE);
endmodule : acb_core_assertions
bind acb_core acb_core_assertions acb_core_assertions_inst (.mclk, .reset, .cmd_valid,
   .cmd_op, .cmd_rd, .cmd_k, .cmd_ready, .done, .pc, .sreg, .ret_push, .ret_addr,
   .io_bit_we, .io_addr, .io_bit_sel, .io_bit_value);
`default_nettype wire

// [testbench/acb_core_tb_top.sv]
// self-checking bench for the execution core
`timescale 1ns/1ns
`default_nettype none
module acb_core_tb_top;
   typedef struct {acb_pkg::acb_op_t op; logic [15:0] a; logic [7:0] b; logic c;
      logic [15:0] r; logic [7:0] f; logic [7:0] m; logic [15:0] n;} acb_row_t;
   logic mclk = 1'h0, reset = 1'h1, cmd_valid = 1'h0, cmd_next_two_words = 1'h0, load_we = 1'h0;
   acb_pkg::acb_op_t cmd_op = acb_pkg::OP_NONE;
   logic [4:0] cmd_rd = 5'h00, cmd_rr = 5'h00, load_addr = 5'h00, peek_addr = 5'h00;
   logic [7:0] cmd_k = 8'h00, load_data = 8'h00, io_rd_data = 8'h80;
   logic [11:0] cmd_offset = 12'h000;
   logic cmd_ready, done, ret_push, io_bit_we, io_bit_value;
   logic [15:0] pc, ret_addr, p0, n;
   logic [7:0] sreg, peek_data, lo, hi;
   logic [4:0] io_addr;
   logic [2:0] io_bit_sel;
   int failures = 0, n_tests = 0, cyc_cnt = 0;
   acb_row_t rows[16] = '{
      '{acb_pkg::OP_SUM, 16'h000F, 8'h01, 1'h0, 16'h0010, 8'h20, 8'h3F, 16'h1},
      '{acb_pkg::OP_SUM_WITH_CARRY, 16'h007F, 8'h00, 1'h1, 16'h0080, 8'h2C, 8'h3F, 16'h1},
      '{acb_pkg::OP_WORD_IMMEDIATE_SUM, 16'hFFFF, 8'h01, 1'h0, 16'h0000, 8'h03, 8'h1F, 16'h2},
      '{acb_pkg::OP_DIFFERENCE, 16'h0010, 8'h01, 1'h0, 16'h000F, 8'h20, 8'h3F, 16'h1},
      '{acb_pkg::OP_CONSTANT_DIFFERENCE, 16'h0000, 8'h01, 1'h0, 16'h00FF, 8'h35, 8'h3F, 16'h1},
      '{acb_pkg::OP_DIFFERENCE_WITH_BORROW, 16'h0005, 8'h05, 1'h1, 16'h00FF, 8'h35, 8'h3F, 16'h1},
      '{acb_pkg::OP_CONSTANT_DIFFERENCE_WITH_BORROW, 16'h0080, 8'h00, 1'h1, 16'h007F, 8'h38, 8'h3F,
         16'h1},
      '{acb_pkg::OP_WORD_IMMEDIATE_DIFF, 16'h0000, 8'h01, 1'h0, 16'hFFFF, 8'h15, 8'h1F, 16'h2},
      '{acb_pkg::OP_CONJUNCTION, 16'h00F0, 8'h0F, 1'h1, 16'h0000, 8'h03, 8'h1F, 16'h1},
      '{acb_pkg::OP_BITWISE_CONJUNCTION_CONSTANT, 16'h00FF, 8'h81, 1'h0, 16'h0081, 8'h14, 8'h1F, 16'h1},
      '{acb_pkg::OP_DISJUNCTION, 16'h0080, 8'h01, 1'h1, 16'h0081, 8'h15, 8'h1F, 16'h1},
      '{acb_pkg::OP_BITWISE_DISJUNCTION_CONSTANT, 16'h0000, 8'h00, 1'h0, 16'h0000, 8'h02, 8'h1F, 16'h1},
      '{acb_pkg::OP_EXCLUSIVE_DISJUNCTION, 16'h00AA, 8'hAA, 1'h1, 16'h0000, 8'h03, 8'h1F, 16'h1},
      '{acb_pkg::OP_SET_BITS_MASK, 16'h0001, 8'h40, 1'h0, 16'h0041, 8'h00, 8'h1F, 16'h1},
      '{acb_pkg::OP_CLEAR_BITS_MASK, 16'h00FF, 8'h0F, 1'h1, 16'h00F0, 8'h15, 8'h1F, 16'h1},
      '{acb_pkg::OP_ZERO_SIGN_TEST, 16'h0080, 8'h00, 1'h0, 16'h0080, 8'h14, 8'h1F, 16'h1}};
   always #2 mclk = ~mclk;
   acb_core acb_core_inst (.mclk, .reset, .cmd_valid, .cmd_op, .cmd_rd, .cmd_rr, .cmd_k,
      .cmd_offset, .cmd_next_two_words, .cmd_ready, .done, .pc, .sreg, .ret_push, .ret_addr,
      .io_bit_we, .io_addr, .io_bit_sel, .io_bit_value, .io_rd_data, .load_we, .load_addr,
      .load_data, .peek_addr, .peek_data);
   // ----------------------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic load(input logic [4:0] r, input logic [7:0] d);
      @(posedge mclk);
      load_we <= 1'h1;
      load_addr <= r;
      load_data <= d;
      @(posedge mclk);
      load_we <= 1'h0;
   endtask : load
   task automatic peek(input logic [4:0] r, output logic [7:0] d);
      @(posedge mclk);
      peek_addr <= r;
      repeat (2) @(posedge mclk);
      #1 d = peek_data;
   endtask : peek
   // n counts edges to done; bounded against a hang
   task automatic run(input acb_pkg::acb_op_t op, input logic [4:0] rd, input logic [4:0] rr,
      input logic [7:0] k, input logic [11:0] off, input logic two);
      p0 = pc;
      @(posedge mclk);
      cmd_valid <= 1'h1;
      cmd_op <= op;
      cmd_rd <= rd;
      cmd_rr <= rr;
      cmd_k <= k;
      cmd_offset <= off;
      cmd_next_two_words <= two;
      @(posedge mclk);
      cmd_valid <= 1'h0;
      #1 n = 16'h1;
      while (done !== 1'h1 && n < 16'h8)
      begin
         @(posedge mclk);
         #1 n++;
      end
   endtask : run
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict
   always @(posedge mclk)
   begin
      cyc_cnt++;
      if (cyc_cnt == 5000)
      begin
         failures++;
         print_verdict();
      end
   end
   initial
   begin
      repeat (12) @(posedge mclk);
      chk("reset pc", 16'h0000, pc);
      chk("reset flags", 16'h0000, {8'h00, sreg});
      chk("reset ready", 16'h0001, {15'h0000, cmd_ready});
      reset <= 1'h0;
      foreach (rows[i])
      begin
         load(5'h12, rows[i].c ? 8'h80 : 8'h00);
         run(acb_pkg::OP_SUM, 5'h12, 5'h12, 8'h00, 12'h000, 1'h0);
         load(5'h18, rows[i].a[7:0]);
         load(5'h19, rows[i].a[15:8]);
         load(5'h14, rows[i].b);
         run(rows[i].op, 5'h18, 5'h14, rows[i].b, 12'h000, 1'h0);
         chk("cycles", rows[i].n, n);
         chk("flags", {8'h00, rows[i].f & rows[i].m}, {8'h00, sreg & rows[i].m});
         peek(5'h18, lo);
         peek(5'h19, hi);
         chk("result", rows[i].r, {hi, lo});
      end
      load(5'h1E, 8'h34);
      load(5'h1F, 8'h12);
      run(acb_pkg::OP_INDIRECT_SUBROUTINE_CALL, 5'h00, 5'h00, 8'h00, 12'h000, 1'h0);
      chk("indirect_subroutine_call pc", 16'h1234, pc + n - 16'h3);
      load(5'h1E, 8'h40);
      load(5'h1F, 8'h00);
      run(acb_pkg::OP_INDIRECT_JUMP_VIA_POINTER, 5'h00, 5'h00, 8'h00, 12'h000, 1'h0);
      chk("indirect_jump_via_pointer pc", 16'h0040, pc + n - 16'h2);
      run(acb_pkg::OP_RELATIVE_SUBROUTINE_CALL, 5'h00, 5'h00, 8'h00, 12'hFFE, 1'h0);
      chk("relative_subroutine_call pc", 16'h003F, pc + n - 16'h3);
      run(acb_pkg::OP_COMPARE_SKIP_EQUAL, 5'h12, 5'h12, 8'h00, 12'h000, 1'h1);
      chk("skip pc", p0 + 16'h3, pc + n - 16'h3);
      run(acb_pkg::OP_COMPARE_SKIP_EQUAL, 5'h12, 5'h18, 8'h00, 12'h000, 1'h0);
      chk("no skip pc", p0 + 16'h1, pc + n - 16'h1);
      run(acb_pkg::OP_IO_BIT_SET, 5'h1F, 5'h00, 8'h07, 12'h000, 1'h0);
      chk("io set cycles", 16'h2, n);
      run(acb_pkg::OP_IO_BIT_CLEAR, 5'h00, 5'h00, 8'h02, 12'h000, 1'h0);
      chk("io clear cycles", 16'h2, n);
      run(acb_pkg::OP_IO_BIT_SKIP_IF_ONE, 5'h1F, 5'h00, 8'h07, 12'h000, 1'h1);
      chk("io skip pc", p0 + 16'h3, pc + n - 16'h3);
      run(acb_pkg::OP_IO_BIT_SKIP_IF_ZERO, 5'h1F, 5'h00, 8'h07, 12'h000, 1'h0);
      chk("io stay pc", p0 + 16'h1, pc + n - 16'h2);
      print_verdict();
   end
endmodule : acb_core_tb_top
`default_nettype wire
